// [vcsr_regs.sv]
// Vendor control and status registers 27 to 31 of a 10/100 transceiver.
//
// Function
// - Source select picks pins or register bits.
// - Register auto crossover bit enables automatic crossover.
// - Manual channel bit swaps pairs when manual.
// - Heartbeat disable resets low, one suppresses test.
// - Read-only 10BASE-T polarity bit, reset zero.
// - Seven latched interrupt flags; other bits zero.
// - Link down flag sets on falling link.
// - Mask low byte enables sources, high read-only.
// - Primary mode: irq released on revert/read.
// - Alternate mode: write one rechecks, clears if idle.
// - Autonegotiation done bit reads completion, reset zero.
// - Three-bit field drives general outputs, reset zero.
// - Coder enable resets one; zero bypasses coder.
// - Read-only resolved speed and duplex code.
// - Scrambler disable resets zero; one stops scrambling.
`timescale 1ns/1ps
`default_nettype none

module vcsr_regs (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register port from the serial management frame engine.
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rdata_valid,
  // Crossover pins and effective crossover control.
  input wire logic crossover_enable_pin,
  input wire logic channel_select_pin,
  output logic auto_crossover_active,
  output logic pairs_swapped,
  // Status from the receive, link and negotiation logic.
  input wire logic tenbase_polarity_reversed,
  input wire logic line_energy_present,
  input wire logic autoneg_complete,
  input wire logic remote_fault,
  input wire logic link_status,
  input wire logic partner_ack,
  input wire logic parallel_detect_fault,
  input wire logic page_received,
  input wire logic autoneg_done,
  input wire logic [2:0] resolved_speed_duplex,
  input wire logic alternate_irq_mode,
  // Control outputs to the datapath and pins.
  output logic heartbeat_test_disable,
  output logic [2:0] general_outputs,
  output logic coder_enable,
  output logic scrambler_disable,
  output logic irq_out_n
);

  // ------------------------------------------------------------------
  // Address decode helper, shared by the read and write paths.
  // ------------------------------------------------------------------
  function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] t);
    addr_hit = (a == t);
  endfunction

  // ------------------------------------------------------------------
  // Writable control state.
  // ------------------------------------------------------------------
  logic xover_src_reg, xover_src_next;
  logic auto_xover_reg, auto_xover_next;
  logic chan_sel_reg, chan_sel_next;
  logic hb_dis_reg, hb_dis_next;
  logic [7:0] mask_reg, mask_next;
  logic [2:0] gpo_reg, gpo_next;
  logic coder_en_reg, coder_en_next;
  logic scr_dis_reg, scr_dis_next;

  logic wr_xover;
  logic wr_mask;
  logic wr_special;
  logic wr_flags;
  logic rd_flags;

  // Write strobes and the flag read strobe; the testability location decodes to nothing at all.
  always_comb begin
    wr_xover = mgmt_wr && addr_hit(mgmt_addr, vcsr_pkg::ADDR_XOVER);
    wr_mask = mgmt_wr && addr_hit(mgmt_addr, vcsr_pkg::ADDR_MASK);
    wr_special = mgmt_wr && addr_hit(mgmt_addr, vcsr_pkg::ADDR_SPECIAL);
    wr_flags = mgmt_wr && addr_hit(mgmt_addr, vcsr_pkg::ADDR_FLAGS);
    rd_flags = mgmt_rd && addr_hit(mgmt_addr, vcsr_pkg::ADDR_FLAGS);
  end

  // Next values of the writable fields. Only writable bits are picked
  // out of the write data, so read-only and reserved bits stay put.
  always_comb begin
    xover_src_next = xover_src_reg;
    auto_xover_next = auto_xover_reg;
    chan_sel_next = chan_sel_reg;
    hb_dis_next = hb_dis_reg;
    mask_next = mask_reg;
    gpo_next = gpo_reg;
    coder_en_next = coder_en_reg;
    scr_dis_next = scr_dis_reg;
    if (wr_xover) begin
      xover_src_next = mgmt_wdata[vcsr_pkg::XOVER_SRC_BIT];
      auto_xover_next = mgmt_wdata[vcsr_pkg::AUTO_XOVER_BIT];
      chan_sel_next = mgmt_wdata[vcsr_pkg::CHAN_SEL_BIT];
      hb_dis_next = mgmt_wdata[vcsr_pkg::HB_DIS_BIT];
    end
    if (wr_mask) begin
      mask_next = mgmt_wdata[vcsr_pkg::MASK_MSB:0];
    end
    if (wr_special) begin
      gpo_next = mgmt_wdata[vcsr_pkg::GPO_MSB:vcsr_pkg::GPO_LSB];
      coder_en_next = mgmt_wdata[vcsr_pkg::CODER_BIT];
      scr_dis_next = mgmt_wdata[vcsr_pkg::SCR_DIS_BIT];
    end
  end

  // Register the control fields with their reset values.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xover_src_reg <= 1'b0;
      auto_xover_reg <= 1'b0;
      chan_sel_reg <= 1'b0;
      hb_dis_reg <= 1'b0;
      mask_reg <= vcsr_pkg::MASK_RST;
      gpo_reg <= vcsr_pkg::GPO_RST;
      coder_en_reg <= vcsr_pkg::CODER_RST;
      scr_dis_reg <= 1'b0;
    end else begin
      xover_src_reg <= xover_src_next;
      auto_xover_reg <= auto_xover_next;
      chan_sel_reg <= chan_sel_next;
      hb_dis_reg <= hb_dis_next;
      mask_reg <= mask_next;
      gpo_reg <= gpo_next;
      coder_en_reg <= coder_en_next;
      scr_dis_reg <= scr_dis_next;
    end
  end

  // ------------------------------------------------------------------
  // Read-only status snapshots.
  // ------------------------------------------------------------------
  logic pol_reg, pol_next;
  logic autodone_reg, autodone_next;
  logic [2:0] speed_reg, speed_next;

  // Status follows the live inputs; management writes never touch it.
  always_comb begin
    pol_next = tenbase_polarity_reversed;
    autodone_next = autoneg_done;
    speed_next = resolved_speed_duplex;
  end

  // Register the status snapshots.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pol_reg <= 1'b0;
      autodone_reg <= 1'b0;
      speed_reg <= vcsr_pkg::SPEED_RST;
    end else begin
      pol_reg <= pol_next;
      autodone_reg <= autodone_next;
      speed_reg <= speed_next;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt flag bank.
  // ------------------------------------------------------------------
  vcsr_flag_if flag_bus ();

  // Source levels are packed with flag bit 1 in the lowest slot.
  assign flag_bus.src = {line_energy_present, autoneg_complete, remote_fault,
                         link_status, partner_ack, parallel_detect_fault,
                         page_received};
  // Reading the flags releases them only in primary mode.
  assign flag_bus.read_clear = rd_flags;
  // A write is a recheck request only in alternate mode; in primary
  // mode the flags are read-only and the write has no effect.
  assign flag_bus.recheck = (wr_flags && alternate_irq_mode) ?
    mgmt_wdata[vcsr_pkg::FLAG_MSB:vcsr_pkg::FLAG_LSB] :
    vcsr_pkg::SRC_ZERO;
  assign flag_bus.alt_mode = alternate_irq_mode;

  vcsr_flag_bank #(
    .FALL_MASK(vcsr_pkg::FALL_SRC_MASK)
  ) u_flags (
    .clk(clk),
    .reset(reset),
    .fi(flag_bus.bank)
  );

  // ------------------------------------------------------------------
  // Read path and registered outputs.
  // ------------------------------------------------------------------
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic irq_n_reg, irq_n_next;
  logic xover_act_reg, xover_act_next;
  logic swap_reg, swap_next;

  // Read mux. Reserved bits, the testability register and unmapped
  // locations read as zero; the flags are shown before any release.
  always_comb begin
    rdata_next = vcsr_pkg::WORD_ZERO;
    rvalid_next = mgmt_rd;
    if (addr_hit(mgmt_addr, vcsr_pkg::ADDR_XOVER)) begin
      rdata_next[vcsr_pkg::XOVER_SRC_BIT] = xover_src_reg;
      rdata_next[vcsr_pkg::AUTO_XOVER_BIT] = auto_xover_reg;
      rdata_next[vcsr_pkg::CHAN_SEL_BIT] = chan_sel_reg;
      rdata_next[vcsr_pkg::HB_DIS_BIT] = hb_dis_reg;
      rdata_next[vcsr_pkg::POL_BIT] = pol_reg;
    end else if (addr_hit(mgmt_addr, vcsr_pkg::ADDR_FLAGS)) begin
      rdata_next[vcsr_pkg::FLAG_MSB:vcsr_pkg::FLAG_LSB] = flag_bus.flags;
    end else if (addr_hit(mgmt_addr, vcsr_pkg::ADDR_MASK)) begin
      rdata_next[vcsr_pkg::MASK_MSB:0] = mask_reg;
    end else if (addr_hit(mgmt_addr, vcsr_pkg::ADDR_SPECIAL)) begin
      rdata_next[vcsr_pkg::AUTODONE_BIT] = autodone_reg;
      rdata_next[vcsr_pkg::GPO_MSB:vcsr_pkg::GPO_LSB] = gpo_reg;
      rdata_next[vcsr_pkg::CODER_BIT] = coder_en_reg;
      rdata_next[vcsr_pkg::SPEED_MSB:vcsr_pkg::SPEED_LSB] = speed_reg;
      rdata_next[vcsr_pkg::SCR_DIS_BIT] = scr_dis_reg;
    end
  end

  // Effective crossover control and the interrupt pin. The pin is
  // computed from the next flag and mask values so that it follows
  // the flags in the same cycle rather than one cycle later.
  always_comb begin
    if (xover_src_next) begin
      xover_act_next = auto_xover_next;
      swap_next = !auto_xover_next && chan_sel_next;
    end else begin
      xover_act_next = crossover_enable_pin;
      swap_next = !crossover_enable_pin && channel_select_pin;
    end
    irq_n_next = !(|(flag_bus.flags_next &
                     mask_next[vcsr_pkg::FLAG_MSB:vcsr_pkg::FLAG_LSB]));
  end

  // Register the read answer and the derived outputs.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= vcsr_pkg::WORD_ZERO;
      rvalid_reg <= 1'b0;
      irq_n_reg <= 1'b1;
      xover_act_reg <= 1'b0;
      swap_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      irq_n_reg <= irq_n_next;
      xover_act_reg <= xover_act_next;
      swap_reg <= swap_next;
    end
  end

  assign mgmt_rdata = rdata_reg;
  assign mgmt_rdata_valid = rvalid_reg;
  assign auto_crossover_active = xover_act_reg;
  assign pairs_swapped = swap_reg;
  assign heartbeat_test_disable = hb_dis_reg;
  assign general_outputs = gpo_reg;
  assign coder_enable = coder_en_reg;
  assign scrambler_disable = scr_dis_reg;
  assign irq_out_n = irq_n_reg;

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_pin_mode_follow: assert property (
    (!xover_src_reg && !wr_xover) |=> (auto_crossover_active == $past(crossover_enable_pin)))
    else $error("pins did not govern crossover");
  a_manual_swap: assert property (
    (xover_src_reg && !auto_xover_reg && !wr_xover) |=> (pairs_swapped == $past(chan_sel_reg)))
    else $error("manual channel choice not applied");
  a_auto_no_swap: assert property (
    (xover_src_reg && auto_xover_reg && !wr_xover) |=> (auto_crossover_active && !pairs_swapped))
    else $error("register crossover enable ignored");
  a_hb_write: assert property (
    wr_xover |=> (heartbeat_test_disable == $past(mgmt_wdata[vcsr_pkg::HB_DIS_BIT])))
    else $error("heartbeat disable not stored");
  a_flag_read_zero: assert property (
    (mgmt_rd && addr_hit(mgmt_addr, vcsr_pkg::ADDR_FLAGS)) |=>
      (mgmt_rdata_valid && mgmt_rdata[15:8] == 8'h00 && !mgmt_rdata[0]))
    else $error("reserved flag bits read nonzero");
  a_mask_high_zero: assert property (
    (mgmt_rd && addr_hit(mgmt_addr, vcsr_pkg::ADDR_MASK)) |=> mgmt_rdata[15:8] == 8'h00)
    else $error("mask high byte not read-only zero");
  a_irq_masked: assert property (
    (mask_next == vcsr_pkg::MASK_RST) |=> irq_out_n)
    else $error("interrupt asserted with all sources masked");
  a_primary_release: assert property (
    (!alternate_irq_mode && rd_flags && flag_bus.src[6] && $stable(flag_bus.src))
      |=> !flag_bus.flags[6])
    else $error("flag not released by a read in primary mode");
  a_gpo_drive: assert property (
    wr_special |=> (general_outputs == $past(mgmt_wdata[vcsr_pkg::GPO_MSB:vcsr_pkg::GPO_LSB])))
    else $error("general outputs not driven by the field");
  a_ro_unchanged: assert property (
    (wr_special && $stable(resolved_speed_duplex) && $stable(autoneg_done)) |=>
      ($stable(speed_reg) && $stable(autodone_reg)))
    else $error("write disturbed read-only status");
  a_speed_code: assert property (
    (speed_reg == vcsr_pkg::SPEED_10_FULL) |->
      $past(resolved_speed_duplex) == vcsr_pkg::SPEED_10_FULL)
    else $error("speed field does not report the resolved mode");

endmodule

`default_nettype wire

// [vcsr_pkg.sv]
// Constants shared by the vendor control and status register bank.
package vcsr_pkg;

  // ----------------------------------------------------------------
  // Register locations on the management register port.
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_XOVER = 5'h1B;
  localparam logic [4:0] ADDR_TEST = 5'h1C;
  localparam logic [4:0] ADDR_FLAGS = 5'h1D;
  localparam logic [4:0] ADDR_MASK = 5'h1E;
  localparam logic [4:0] ADDR_SPECIAL = 5'h1F;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int XOVER_SRC_BIT = 15;
  localparam int AUTO_XOVER_BIT = 14;
  localparam int CHAN_SEL_BIT = 13;
  localparam int HB_DIS_BIT = 11;
  localparam int POL_BIT = 4;
  localparam int FLAG_LSB = 1;
  localparam int FLAG_MSB = 7;
  localparam int NUM_SRC = 7;
  localparam int MASK_MSB = 7;
  localparam int AUTODONE_BIT = 12;
  localparam int GPO_LSB = 7;
  localparam int GPO_MSB = 9;
  localparam int CODER_BIT = 6;
  localparam int SPEED_LSB = 2;
  localparam int SPEED_MSB = 4;
  localparam int SCR_DIS_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and encodings.
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [2:0] GPO_RST = 3'h0;
  localparam logic CODER_RST = 1'b1;
  localparam logic [2:0] SPEED_RST = 3'h0;
  localparam logic [2:0] SPEED_10_HALF = 3'h1;
  localparam logic [2:0] SPEED_10_FULL = 3'h5;
  localparam logic [2:0] SPEED_100_HALF = 3'h2;
  localparam logic [2:0] SPEED_100_FULL = 3'h6;
  // Sources whose event is a falling edge (link down, flag bit 4).
  localparam logic [6:0] FALL_SRC_MASK = 7'h08;
  localparam logic [6:0] SRC_ZERO = 7'h00;

endpackage

// [vcsr_flag_if.sv]
// Interface between the register decoder and the latched flag bank.
`timescale 1ns/1ps
`default_nettype none

interface vcsr_flag_if;
  // Raw source levels, read strobe, recheck strobe and the flags.
  logic [6:0] src;
  logic read_clear;
  logic [6:0] recheck;
  logic alt_mode;
  logic [6:0] flags;
  logic [6:0] flags_next;

  modport bank (input src, input read_clear, input recheck, input alt_mode,
                output flags, output flags_next);
  modport ctrl (output src, output read_clear, output recheck, output alt_mode,
                input flags, input flags_next);
endinterface

`default_nettype wire

// [vcsr_flag_bank.sv]
// Latched-high interrupt source flags with primary and alternate release.
`timescale 1ns/1ps
`default_nettype none

module vcsr_flag_bank #(
  parameter logic [6:0] FALL_MASK = vcsr_pkg::FALL_SRC_MASK
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Decoder side.
  vcsr_flag_if.bank fi
);

  logic [6:0] prev_reg;
  logic [6:0] prev_next;
  logic [6:0] flag_reg;
  logic [6:0] flag_next;
  logic [6:0] evt;

  // ------------------------------------------------------------------
  // Edge detection and flag update, one cell per source.
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < vcsr_pkg::NUM_SRC; i = i + 1) begin : g_src
      logic revert;
      logic cond_off;
      logic clr;
      // Link down rises on the falling link level; it never reverts alone.
      assign evt[i] = FALL_MASK[i] ? (prev_reg[i] & ~fi.src[i])
                                   : (~prev_reg[i] & fi.src[i]);
      assign revert = FALL_MASK[i] ? 1'b0 : (prev_reg[i] & ~fi.src[i]);
      assign cond_off = FALL_MASK[i] ? fi.src[i] : ~fi.src[i];
      // Primary: revert or read releases; alternate: recheck then release.
      assign clr = fi.alt_mode ? (fi.recheck[i] & cond_off)
                               : (fi.read_clear | revert);
      // A new event in the clearing cycle wins so it is never lost.
      assign flag_next[i] = evt[i] | (flag_reg[i] & ~clr);
    end
  endgenerate

  // The previous source level simply follows the source.
  always_comb begin
    prev_next = fi.src;
  end

  // Register the bank state.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_reg <= vcsr_pkg::SRC_ZERO;
      flag_reg <= vcsr_pkg::SRC_ZERO;
    end else begin
      prev_reg <= prev_next;
      flag_reg <= flag_next;
    end
  end

  assign fi.flags = flag_reg;
  assign fi.flags_next = flag_next;

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------
  a_link_down_set: assert property (
    @(posedge clk) disable iff (reset)
    (prev_reg[3] && !fi.src[3]) |=> flag_reg[3])
    else $error("link down flag missed a falling link level");
  a_alt_hold_flag: assert property (
    @(posedge clk) disable iff (reset)
    (fi.alt_mode && flag_reg[0] && fi.src[0]) |=> flag_reg[0])
    else $error("flag cleared while its source was still active");

endmodule

`default_nettype wire

// [vcsr_mgmt_model.sv]
// Station management controller model driving the register word port.
`timescale 1ns/1ps
`default_nettype none

module vcsr_mgmt_model (
  // Clock.
  input wire logic clk,
  // Register word port toward the bank.
  output logic [4:0] mgmt_addr,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rdata_valid
);
  // Idle port at time zero.
  initial begin
    mgmt_addr = 5'h00;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 16'h0000;
  end

  // One-cycle write strobe; data is scrambled afterwards so stale words are never trusted.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    if (a != vcsr_pkg::ADDR_TEST) begin
      @(posedge clk);
      mgmt_addr <= a;
      mgmt_wdata <= (a == vcsr_pkg::ADDR_XOVER) ? (d & ~16'h17E0) : d;
      mgmt_wr <= 1'b1;
      @(posedge clk);
      mgmt_wr <= 1'b0;
      mgmt_addr <= ~a;
      mgmt_wdata <= ~d;
    end
  endtask

  // One-cycle read strobe; the word is taken only while valid is high.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    mgmt_addr <= a;
    mgmt_rd <= 1'b1;
    @(posedge clk);
    mgmt_rd <= 1'b0;
    mgmt_addr <= ~a;
    #1;
    d = mgmt_rdata_valid ? mgmt_rdata : 16'hXXXX;
  endtask
endmodule

`default_nettype wire

// [vcsr_tb.sv]
// Self-checking bench for the vendor control and status register bank.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("CHECK FAILED at %0t got %h exp %h", $time, (g), (e)); \
    end \
  end

module tb;
  // ----------------------------------------------------------------
  // Signals and instances.
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] mgmt_addr;
  logic mgmt_wr, mgmt_rd, mgmt_rdata_valid;
  logic [15:0] mgmt_wdata, mgmt_rdata, rdv;
  logic xpin = 1'b0, chpin = 1'b0, pol = 1'b0, done = 1'b0, alt = 1'b0;
  logic [2:0] speed = 3'h0;
  logic [2:0] gpo;
  // Bit i drives flag i+1; bit 3 is link loss, so link status is its inverse.
  logic [6:0] src_lvl = 7'h00;
  logic auto_act, swapped, hb_dis, coder_en, scr_dis, irq_n;
  logic [2:0] codes [4] = '{vcsr_pkg::SPEED_10_HALF, vcsr_pkg::SPEED_10_FULL,
                           vcsr_pkg::SPEED_100_HALF, vcsr_pkg::SPEED_100_FULL};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  vcsr_regs dut (.clk(clk), .reset(reset), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rdata_valid(mgmt_rdata_valid), .crossover_enable_pin(xpin),
    .channel_select_pin(chpin), .auto_crossover_active(auto_act), .pairs_swapped(swapped),
    .tenbase_polarity_reversed(pol), .line_energy_present(src_lvl[6]),
    .autoneg_complete(src_lvl[5]), .remote_fault(src_lvl[4]), .link_status(~src_lvl[3]),
    .partner_ack(src_lvl[2]), .parallel_detect_fault(src_lvl[1]),
    .page_received(src_lvl[0]), .autoneg_done(done), .resolved_speed_duplex(speed),
    .alternate_irq_mode(alt), .heartbeat_test_disable(hb_dis), .general_outputs(gpo),
    .coder_enable(coder_en), .scrambler_disable(scr_dis), .irq_out_n(irq_n));

  vcsr_mgmt_model mgmt (.clk(clk), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rdata_valid(mgmt_rdata_valid));

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;

  // Cycle ceiling; the whole sequence needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic drive_src(input logic [6:0] v);
    @(posedge clk);
    src_lvl <= v;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    mgmt.rd(a, d);
    `CHK(d, e)
  endtask

  // Bounded wait for the interrupt level, then compare it. It steps off
  // the clock edge first, so a level launched on that edge is never read early.
  task automatic wait_irq(input logic lvl);
    #1;
    for (int k = 0; k < 6 && irq_n !== lvl; k++) begin
      tick();
    end
    `CHK(irq_n, lvl)
  endtask

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    tick();
    `CHK(coder_en, 1'b1)
    `CHK({hb_dis, gpo, scr_dis, auto_act, swapped, irq_n}, 8'h01)
    rd_chk(vcsr_pkg::ADDR_XOVER, 16'h0000);
    rd_chk(vcsr_pkg::ADDR_FLAGS, 16'h0000);
    rd_chk(vcsr_pkg::ADDR_MASK, 16'h0000);
    rd_chk(vcsr_pkg::ADDR_SPECIAL, 16'h0040);
    rd_chk(5'h05, 16'h0000);
    $display("test reset done");

    // Pins govern first; then the register bits take over while the pins disagree.
    @(posedge clk);
    pol <= 1'b1;
    xpin <= 1'b1;
    repeat (2) tick();
    `CHK({auto_act, swapped}, 2'b10)
    @(posedge clk);
    xpin <= 1'b0;
    chpin <= 1'b1;
    repeat (2) tick();
    `CHK({auto_act, swapped}, 2'b01)
    mgmt.wr(vcsr_pkg::ADDR_XOVER, 16'hF800);
    tick();
    `CHK({auto_act, swapped, hb_dis}, 3'b101)
    rd_chk(vcsr_pkg::ADDR_XOVER, 16'hE810);
    mgmt.wr(vcsr_pkg::ADDR_XOVER, 16'h8000);
    tick();
    `CHK({auto_act, swapped, hb_dis}, 3'b000)
    mgmt.wr(vcsr_pkg::ADDR_XOVER, 16'hA00F);
    tick();
    `CHK({auto_act, swapped}, 2'b01)
    rd_chk(vcsr_pkg::ADDR_XOVER, 16'hA010);
    mgmt.wr(vcsr_pkg::ADDR_TEST, 16'h1234);
    mgmt.rd(vcsr_pkg::ADDR_TEST, rdv);
    $display("test crossover done");

    // The bench port stands for an MII attachment, so bypassing the coder is allowed.
    mgmt.wr(vcsr_pkg::ADDR_MASK, 16'hFFFF);
    rd_chk(vcsr_pkg::ADDR_MASK, 16'h00FF);
    mgmt.wr(vcsr_pkg::ADDR_SPECIAL, 16'h139D);
    tick();
    `CHK({gpo, coder_en, scr_dis}, 5'b11101)
    rd_chk(vcsr_pkg::ADDR_SPECIAL, 16'h0381);
    foreach (codes[i]) begin
      @(posedge clk);
      speed <= codes[i];
      done <= i[0];
      tick();
      rd_chk(vcsr_pkg::ADDR_SPECIAL, 16'h0381 | {3'h0, i[0], 7'h00, codes[i], 2'b00});
    end
    $display("test special done");

    // Masked source still latches its flag but leaves the output released.
    mgmt.wr(vcsr_pkg::ADDR_MASK, 16'h0000);
    drive_src(7'h40);
    repeat (4) tick();
    `CHK(irq_n, 1'b1)
    rd_chk(vcsr_pkg::ADDR_FLAGS, 16'h0080);
    drive_src(7'h00);
    mgmt.wr(vcsr_pkg::ADDR_MASK, 16'h00FE);
    for (int i = 0; i < 7; i++) begin
      drive_src(7'(1 << i));
      wait_irq(1'b0);
      rd_chk(vcsr_pkg::ADDR_FLAGS, 16'(2 << i));
      wait_irq(1'b1);
      drive_src(7'h00);
    end
    drive_src(7'h10);
    wait_irq(1'b0);
    drive_src(7'h00);
    wait_irq(1'b1);
    rd_chk(vcsr_pkg::ADDR_FLAGS, 16'h0000);
    $display("test primary done");

    // Recheck while the source is active must keep the flag; later it clears.
    @(posedge clk);
    alt <= 1'b1;
    drive_src(7'h01);
    wait_irq(1'b0);
    mgmt.wr(vcsr_pkg::ADDR_FLAGS, 16'h0002);
    repeat (3) tick();
    `CHK(irq_n, 1'b0)
    drive_src(7'h00);
    repeat (3) tick();
    `CHK(irq_n, 1'b0)
    mgmt.wr(vcsr_pkg::ADDR_FLAGS, 16'h0002);
    wait_irq(1'b1);
    rd_chk(vcsr_pkg::ADDR_FLAGS, 16'h0000);
    $display("test alternate done");
    finish_test();
  end
endmodule

`undef CHK
`default_nettype wire
